// File: common/pcnt_pkg.sv
package pcnt_pkg;

	// Counter geometry and values
	localparam int CNT_W = 4;
	localparam logic [3:0] CNT_RESET = 4'h0;
	localparam logic [3:0] CNT_MAX = 4'hF;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [3:0] PRESET_RESET = 4'h0;

	////////////////////////////////////////////////////////////////////////
	// Register bus map, byte addresses
	localparam int WB_AW = 4;
	localparam int WB_DW = 32;
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_PRESET = 4'h4;
	localparam logic [3:0] ADDR_CMD = 4'h8;

	// Field positions
	localparam int ST_CARRY_BIT = 4;
	localparam int ST_PEND_BIT = 5;
	localparam int CMD_LOAD_BIT = 0;

	////////////////////////////////////////////////////////////////////////
	function automatic logic isMax(input logic [3:0] v);
		return v == CNT_MAX;
	endfunction

	function automatic logic [3:0] incr(input logic [3:0] v);
		return v + CNT_ONE;
	endfunction

endpackage

// File: hdl/carry_logic.sv
`timescale 1ns/100ps
module carry_logic
	import pcnt_pkg::*;
(
	input wire logic [3:0] count, // Current count
	input wire logic enableP, // Count permit
	input wire logic enableT, // Carry-chain enable
	input wire logic loadN, // Load, active low
	output logic countEn, // Advance at next edge
	output logic carry // Terminal count
);

	always_comb begin
		countEn = enableP & enableT & loadN;
		// Not gated by load or permit, so a held maximum still carries
		carry = enableT & isMax(count);
	end

endmodule

// File: hdl/counter_core.sv
`timescale 1ns/100ps
module counter_core
	import pcnt_pkg::*;
#(
	parameter bit ASYNC_CLEAR = 1'b1 // 1: clear acts without the clock
) (
	input wire logic mclk, // System clock
	input wire logic reset, // Synchronous reset, active high
	input wire logic clearN, // Counter clear, active low
	input wire logic loadN, // Preset load, active low
	input wire logic countEn, // Advance enable
	input wire logic swPend, // Software load pending
	input wire logic [3:0] presetIn, // Preset from pins
	input wire logic [3:0] swPreset, // Preset from register
	output logic [3:0] count, // Count state
	output logic swLoadTaken // Software load done this edge
);

	logic [3:0] count_ff;
	logic [3:0] nxt_count;

	always_comb begin
		nxt_count = count_ff;
		swLoadTaken = 1'b0;
		if (!clearN) begin
			nxt_count = CNT_RESET;
		end else if (!loadN) begin
			nxt_count = presetIn;
		end else if (swPend) begin
			nxt_count = swPreset;
			swLoadTaken = 1'b1;
		end else if (countEn) begin
			nxt_count = incr(count_ff);
		end
	end

	generate
		if (ASYNC_CLEAR) begin : g_async
			always_ff @(posedge mclk or negedge clearN) begin
				if (!clearN) begin
					count_ff <= CNT_RESET;
				end else if (reset) begin
					count_ff <= CNT_RESET;
				end else begin
					count_ff <= nxt_count;
				end
			end
		end else begin : g_sync
			always_ff @(posedge mclk) begin
				if (reset) begin
					count_ff <= CNT_RESET;
				end else begin
					count_ff <= nxt_count;
				end
			end
		end
	endgenerate

	assign count = count_ff;

endmodule

// File: hdl/presettable_counter.sv
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/100ps
module presettable_counter
	import pcnt_pkg::*;
#(
	parameter bit ASYNC_CLEAR = 1'b1 // 1: clear acts without the clock
) (
	input wire logic mclk, // 20 MHz system clock
	input wire logic reset, // Synchronous reset, active high
	input wire logic clearN, // Counter clear, active low
	input wire logic loadN, // Preset load, active low
	input wire logic enableP, // Count permit
	input wire logic enableT, // Carry-chain enable
	input wire logic [3:0] presetIn, // Preset value
	output logic [3:0] countOut, // Count value
	output logic carryOut, // Terminal count for cascading
	input wire logic cyc_i, // Wishbone cycle
	input wire logic stb_i, // Wishbone strobe
	input wire logic we_i, // Wishbone write enable
	input wire logic [3:0] adr_i, // Wishbone byte address
	input wire logic [3:0] sel_i, // Wishbone byte lanes
	input wire logic [31:0] dat_i, // Wishbone write data
	output logic [31:0] dat_o, // Wishbone read data
	output logic ack_o // Wishbone acknowledge
);

	////////////////////////////////////////////////////////////////////////
	// Counter datapath

	logic countEn;
	logic swLoadTaken;
	logic [3:0] count;

	logic ack_ff;
	logic nxt_ack;
	logic [31:0] datO_ff;
	logic [31:0] nxt_datO;
	logic [3:0] swPreset_ff;
	logic [3:0] nxt_swPreset;
	logic swPend_ff;
	logic nxt_swPend;
	logic access;
	logic wrLane0;

	carry_logic u_carry (
		.count(count),
		.enableP(enableP),
		.enableT(enableT),
		.loadN(loadN),
		.countEn(countEn),
		.carry(carryOut)
	);

	counter_core #(
		.ASYNC_CLEAR(ASYNC_CLEAR)
	) u_core (
		.mclk(mclk),
		.reset(reset),
		.clearN(clearN),
		.loadN(loadN),
		.countEn(countEn),
		.swPend(swPend_ff),
		.presetIn(presetIn),
		.swPreset(swPreset_ff),
		.count(count),
		.swLoadTaken(swLoadTaken)
	);

	assign countOut = count;

	////////////////////////////////////////////////////////////////////////
	// Wishbone slave and software registers

	always_comb begin
		access = cyc_i & stb_i & ~ack_ff;
		wrLane0 = access & we_i & sel_i[0];
		nxt_ack = access;
		nxt_datO = datO_ff;
		nxt_swPreset = swPreset_ff;
		// Pin load keeps priority, so a software load may wait some edges
		nxt_swPend = swPend_ff & ~swLoadTaken;
		if (access) begin
			nxt_datO = '0;
			case (adr_i)
				ADDR_STATUS: begin
					nxt_datO[CNT_W-1:0] = count;
					nxt_datO[ST_CARRY_BIT] = carryOut;
					nxt_datO[ST_PEND_BIT] = swPend_ff;
				end
				ADDR_PRESET: begin
					nxt_datO[CNT_W-1:0] = swPreset_ff;
				end
				default: begin
					nxt_datO = '0;
				end
			endcase
		end
		if (wrLane0 && adr_i == ADDR_PRESET) begin
			nxt_swPreset = dat_i[CNT_W-1:0];
		end
		// A new request in the cycle the old one is taken is kept
		if (wrLane0 && adr_i == ADDR_CMD && dat_i[CMD_LOAD_BIT]) begin
			nxt_swPend = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			ack_ff <= 1'b0;
			datO_ff <= '0;
			swPreset_ff <= PRESET_RESET;
			swPend_ff <= 1'b0;
		end else begin
			ack_ff <= nxt_ack;
			datO_ff <= nxt_datO;
			swPreset_ff <= nxt_swPreset;
			swPend_ff <= nxt_swPend;
		end
	end

	assign ack_o = ack_ff;
	assign dat_o = datO_ff;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge mclk);
	endclocking

	default disable iff (reset);

	logic runNow;
	assign runNow = clearN & loadN & ~swPend_ff;

	// Clear may strike between edges, so count checks want clearN still high after
	logic cmdWrite;
	assign cmdWrite = wrLane0 & (adr_i == ADDR_CMD) & dat_i[CMD_LOAD_BIT];

	property p_clear;
		!clearN |=> countOut == CNT_RESET;
	endproperty
	a_clear: assert property (p_clear)
		else $error("count not zero after clear");

	property p_clearBeatsLoad;
		!clearN && !loadN |=> countOut == CNT_RESET;
	endproperty
	a_clearBeatsLoad: assert property (p_clearBeatsLoad)
		else $error("load won over clear");

	property p_syncClearWaits;
		!ASYNC_CLEAR && clearN && $past(clearN) && $rose(countOut == CNT_RESET)
			|-> !$past(clearN) || $past(loadN) == 1'b0 || $past(swPend_ff)
			|| $past(countEn);
	endproperty
	a_syncClearWaits: assert property (p_syncClearWaits)
		else $error("count went to zero with no cause");

	property p_asyncClear;
		ASYNC_CLEAR && !clearN |-> countOut == CNT_RESET;
	endproperty
	a_asyncClear: assert property (p_asyncClear)
		else $error("clear waited for the clock");

	property p_syncClearLate;
		!ASYNC_CLEAR && $fell(clearN) && $past(loadN) && !$past(countEn)
			&& !$past(swPend_ff) |-> countOut == $past(countOut);
	endproperty
	a_syncClearLate: assert property (p_syncClearLate)
		else $error("clear acted between edges");

	property p_load;
		clearN && !loadN ##1 clearN |-> countOut == $past(presetIn);
	endproperty
	a_load: assert property (p_load)
		else $error("preset not loaded");

	property p_loadBits;
		clearN && !loadN ##1 clearN && !loadN
			|-> countOut[0] == $past(presetIn[0]) && countOut[3] == $past(presetIn[3]);
	endproperty
	a_loadBits: assert property (p_loadBits)
		else $error("preset bit order wrong");

	property p_noCountInLoad;
		clearN && !loadN && enableP && enableT && presetIn == countOut ##1 clearN
			|-> countOut == $past(countOut);
	endproperty
	a_noCountInLoad: assert property (p_noCountInLoad)
		else $error("counted while load low");

	property p_swLoad;
		clearN && loadN && swPend_ff ##1 clearN
			|-> countOut == $past(swPreset_ff) && (!swPend_ff || $past(cmdWrite));
	endproperty
	a_swLoad: assert property (p_swLoad)
		else $error("software preset not loaded");

	property p_inc;
		runNow && enableP && enableT ##1 clearN |-> countOut == incr($past(countOut));
	endproperty
	a_inc: assert property (p_inc)
		else $error("count did not advance");

	property p_hold;
		runNow && !(enableP && enableT) ##1 clearN |-> countOut == $past(countOut);
	endproperty
	a_hold: assert property (p_hold)
		else $error("count moved while disabled");

	sequence s_countAtMax;
		runNow && enableP && enableT && isMax(countOut);
	endsequence

	property p_wrap;
		s_countAtMax |=> countOut == CNT_RESET
			and (!(runNow && enableP && enableT) or ##1 (countOut == CNT_ONE || !clearN));
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("no wrap from fifteen to zero");

	property p_carryOnlyAtMax;
		carryOut |-> countOut == CNT_MAX && enableT;
	endproperty
	a_carryOnlyAtMax: assert property (p_carryOnlyAtMax)
		else $error("carry high away from maximum");

	property p_carryDrops;
		carryOut ##1 !isMax(countOut) |-> !carryOut;
	endproperty
	a_carryDrops: assert property (p_carryDrops)
		else $error("carry stayed after leaving maximum");

	property p_carryLow;
		!enableT |-> !carryOut;
	endproperty
	a_carryLow: assert property (p_carryLow)
		else $error("carry high with chain enable low");

	property p_carryHeld;
		enableT && (!enableP || !loadN) && isMax(countOut) |-> carryOut;
	endproperty
	a_carryHeld: assert property (p_carryHeld)
		else $error("held maximum gave no carry");

	property p_ack;
		cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
	endproperty
	a_ack: assert property (p_ack)
		else $error("bus answer not one cycle");

	property p_readCount;
		cyc_i && stb_i && !ack_o && !we_i && adr_i == ADDR_STATUS
			|=> dat_o[CNT_W-1:0] == $past(countOut);
	endproperty
	a_readCount: assert property (p_readCount)
		else $error("status read wrong count");

	property p_edgeOnly;
		clearN && $past(clearN) && countOut != $past(countOut)
			|-> !$past(loadN) || $past(swPend_ff) || $past(countEn);
	endproperty
	a_edgeOnly: assert property (p_edgeOnly)
		else $error("count changed without cause");

	property p_carryEq;
		carryOut == (enableT && countOut == CNT_MAX);
	endproperty
	a_carryEq: assert property (p_carryEq)
		else $error("carry not chain enable and all ones");

	property p_loadStopsCount;
		clearN && !loadN && enableP && enableT && presetIn != incr(countOut) ##1 clearN
			|-> countOut != incr($past(countOut));
	endproperty
	a_loadStopsCount: assert property (p_loadStopsCount)
		else $error("count advanced during load");

	property p_pendWaits;
		(!clearN || !loadN) && swPend_ff |=> swPend_ff;
	endproperty
	a_pendWaits: assert property (p_pendWaits)
		else $error("software load taken over pin load");

	property p_readPreset;
		cyc_i && stb_i && !ack_o && !we_i && adr_i == ADDR_PRESET
			|=> dat_o[CNT_W-1:0] == $past(swPreset_ff);
	endproperty
	a_readPreset: assert property (p_readPreset)
		else $error("preset read wrong value");

	property p_readFlags;
		cyc_i && stb_i && !ack_o && !we_i && adr_i == ADDR_STATUS
			|=> dat_o[ST_CARRY_BIT] == $past(carryOut)
			&& dat_o[ST_PEND_BIT] == $past(swPend_ff);
	endproperty
	a_readFlags: assert property (p_readFlags)
		else $error("status flags read wrong");

	property p_ackAfterReq;
		ack_o |-> $past(cyc_i) && $past(stb_i);
	endproperty
	a_ackAfterReq: assert property (p_ackAfterReq)
		else $error("acknowledge without request");

	////////////////////////////////////////////////////////////////////////
	// Coverage of main scenarios

	property p_covWrap;
		s_countAtMax ##1 countOut == CNT_RESET;
	endproperty
	c_covWrap: cover property (p_covWrap);

	property p_covLoad;
		clearN && !loadN && enableP && enableT;
	endproperty
	c_covLoad: cover property (p_covLoad);

	property p_covSwLoad;
		clearN && loadN && swPend_ff ##1 !swPend_ff;
	endproperty
	c_covSwLoad: cover property (p_covSwLoad);

	property p_covHeldCarry;
		(carryOut && !enableP) [*3];
	endproperty
	c_covHeldCarry: cover property (p_covHeldCarry);

	property p_covPendHeld;
		(!loadN && swPend_ff) [*2];
	endproperty
	c_covPendHeld: cover property (p_covPendHeld);

endmodule

// File: tb/stage_model.sv
`timescale 1ns/100ps
// Next more significant stage of a cascade, advanced only by the lower carry
module stage_model (
	input wire logic mclk, // Shared clock
	input wire logic reset, // Synchronous reset, active high
	input wire logic carryIn, // Lower stage terminal count
	output logic [3:0] hiCount_ff // Upper nibble
);
	logic [3:0] nxt_hiCount;

	always_comb begin
		nxt_hiCount = carryIn ? hiCount_ff + 4'h1 : hiCount_ff;
		if (reset) begin
			nxt_hiCount = 4'h0;
		end
	end

	always_ff @(posedge mclk) begin
		hiCount_ff <= nxt_hiCount;
	end
endmodule

// File: tb/tb.sv
`timescale 1ns/100ps
module tb;
	import pcnt_pkg::*;
	logic mclk, reset, clearN, loadN, enableP, enableT, carryOut;
	logic cyc, stb, we, ack;
	logic [3:0] presetIn, countOut, adr, sel, hiCount, exp, countSync;
	logic [31:0] datI, datO, rd;
	int mismatches, checked;

	presettable_counter uut (.mclk(mclk), .reset(reset), .clearN(clearN), .loadN(loadN),
		.enableP(enableP), .enableT(enableT), .presetIn(presetIn), .countOut(countOut),
		.carryOut(carryOut), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(sel), .dat_i(datI), .dat_o(datO), .ack_o(ack));
	stage_model partner (.mclk(mclk), .reset(reset), .carryIn(carryOut),
		.hiCount_ff(hiCount));
	// Clock-edge clear variant on the same stimulus
	presettable_counter #(.ASYNC_CLEAR(1'b0)) uutSync (.mclk(mclk), .reset(reset),
		.clearN(clearN), .loadN(loadN), .enableP(enableP), .enableT(enableT),
		.presetIn(presetIn), .countOut(countSync), .carryOut(), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datI), .dat_o(), .ack_o());

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
		checked++;
		if (got !== want) begin
			mismatches++;
			$display("MISMATCH t=%0t %s got %0h want %0h", $time, what, got, want);
		end
	endtask

	// Request held until ack is sampled; the slave acks one cycle after the request
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		sel <= 4'hF;
		adr <= a;
		datI <= d;
		@(posedge mclk);
		while (ack !== 1'b1) begin
			@(posedge mclk);
		end
		rd = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic report_and_stop;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (600) @(posedge mclk);
		mismatches++;
		report_and_stop;
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		{reset, clearN, loadN, enableT} = 4'hF;
		{enableP, cyc, stb, we} = 4'h0;
		presetIn = 4'h0;
		adr = 4'h0;
		sel = 4'hF;
		datI = 32'h0;
		mismatches = 0;
		checked = 0;
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		// Load held two edges with enables high must not count
		@(posedge mclk);
		loadN <= 1'b0;
		presetIn <= 4'hC;
		enableP <= 1'b1;
		repeat (2) @(posedge mclk);
		loadN <= 1'b1;
		#1 chk(countOut, 4'hC, "load");
		exp = 4'hC;
		for (int i = 0; i < 5; i++) begin
			@(posedge mclk);
			exp = exp + 4'h1;
			#1 chk(countOut, exp, "count");
			chk(carryOut, exp == 4'hF, "carry");
		end
		chk(hiCount, 4'h1, "cascade");
		$display("count test done");
		// Held at all ones: permit low keeps carry, chain enable low drops it
		@(posedge mclk);
		loadN <= 1'b0;
		presetIn <= 4'hF;
		enableP <= 1'b0;
		@(posedge mclk);
		loadN <= 1'b1;
		@(posedge mclk);
		#1 chk(countOut, 4'hF, "permit low");
		chk(carryOut, 1'b1, "held carry");
		@(posedge mclk);
		enableT <= 1'b0;
		enableP <= 1'b1;
		#1 chk(carryOut, 1'b0, "chain low");
		@(posedge mclk);
		#1 chk(countOut, 4'hF, "chain low hold");
		$display("hold test done");
		// Clear acts before any edge in uut but waits for the edge in uutSync, and beats a load at the same edge
		@(posedge mclk);
		clearN <= 1'b0;
		loadN <= 1'b0;
		presetIn <= 4'h5;
		#1 chk(countOut, 4'h0, "async clear");
		chk(countSync, 4'hF, "sync clear waits");
		@(posedge mclk);
		clearN <= 1'b1;
		#1 chk(countOut, 4'h0, "clear over load");
		chk(countSync, 4'h0, "sync clear");
		@(posedge mclk);
		loadN <= 1'b1;
		#1 chk(countOut, 4'h5, "load after clear");
		$display("clear test done");
		// Software preset path through the register bus
		bus(1'b1, ADDR_PRESET, 32'h9);
		bus(1'b0, ADDR_PRESET, 32'h0);
		chk(rd, 32'h9, "preset reg");
		bus(1'b1, ADDR_CMD, 32'h1);
		@(posedge mclk);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h9, "status");
		bus(1'b0, ADDR_CMD, 32'h0);
		chk(rd, 32'h0, "cmd read");
		bus(1'b0, 4'hC, 32'h0);
		chk(rd, 32'h0, "unmapped");
		// Software load waits behind a held pin load
		@(posedge mclk);
		loadN <= 1'b0;
		presetIn <= 4'hF;
		enableP <= 1'b0;
		enableT <= 1'b1;
		bus(1'b1, ADDR_PRESET, 32'h3);
		bus(1'b1, ADDR_CMD, 32'h1);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h3F, "pending behind load");
		@(posedge mclk);
		loadN <= 1'b1;
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h3, "software load");
		$display("register test done");
		report_and_stop;
	end
endmodule
